// *** pkg/interrupt_accept_timing_defs.vh ***
// Offsets, field positions, reset values and state counts of the interrupt acceptance block
`ifndef INTERRUPT_ACCEPT_TIMING_DEFS_VH
`define INTERRUPT_ACCEPT_TIMING_DEFS_VH

// Register byte offsets
`define SYS_CTRL_OFFSET      8'h00
`define EXT_ENABLE_OFFSET    8'h04
`define EXT_STATUS_OFFSET    8'h08
`define COND_CODE_OFFSET     8'h0c
`define SEQ_STATUS_OFFSET    8'h10
`define STACKED_PC_OFFSET    8'h14

// System control fields
`define NMI_EDGE_BIT         0
`define USER_MASK_MODE_BIT   1
`define MEM_TYPE_LSB         2
`define MEM_TYPE_MSB         4
`define WAIT_LSB             5
`define WAIT_MSB             6

// Condition code fields
`define COND_MASK_BIT        7
`define COND_USER_MASK_BIT   6

// Reset values
`define SYS_CTRL_RESET       8'h02
`define COND_CODE_RESET      8'h80

// Memory types
`define MEM_ONCHIP           3'h0
`define MEM_8BIT_2STATE      3'h1
`define MEM_8BIT_3STATE      3'h2
`define MEM_16BIT_2STATE     3'h3
`define MEM_16BIT_3STATE     3'h4

// State counts
`define PRIO_EXT_STATES      5'h02
`define PRIO_INT_STATES      5'h01
`define INT_PROC_HALF_STATES 5'h02
`define COST_ONCHIP          5'h04
`define COST_8BIT_2STATE     5'h08
`define COST_8BIT_3STATE     5'h0c
`define COST_16BIT_2STATE    5'h04
`define COST_16BIT_3STATE    5'h06

// Instruction codes
`define BREAK_ENTER_CODE     16'h5770
`define BREAK_RETURN_CODE    16'h56f0

`endif

// *** verilog/interrupt_accept_timing.v ***
// Interrupt acceptance timing, inhibition and break mode logic with an AHB-Lite register slave
`timescale 1ns/1ps
//
// Summary of operation
// - Priority decision: external two states, internal one
// - Wait for current instruction end first
// - Stack save and vector fetch cost per memory
// - Prefetch after acceptance and first service instruction
// - Four internal processing states split in two
// - Wait states lengthen stack, vector, prefetch steps
// - Cleared enable keeps request until instruction end
// - Higher pending request wins over cleared one
// - Condition register instructions defer acceptance one instruction
// - Byte block move blocks every interrupt
// - Word block move: only NMI, at boundary
// - Split word move stacks following instruction address
// - Flag cleared by writing zero; one keeps
// - Newly set flag survives a zero written in the same cycle
// - NMI edge chosen by system control bit
// - Break code enters break mode, blocks, halts watchdog
// - Return-from-break code leaves break mode
// - Reset ends break mode
// - NMI never masked; others need mask bit clear, external also enable
// - User mask mode sets both mask bits
`include "interrupt_accept_timing_defs.vh"

module interrupt_accept_timing #(
  parameter EXT_COUNT = 6,
  parameter INT_COUNT = 8
) (
  input  wire                 clock,
  input  wire                 reset,
  input  wire                 hsel,
  input  wire [31:0]          haddr,
  input  wire [1:0]           htrans,
  input  wire                 hwrite,
  input  wire [2:0]           hsize,
  input  wire [31:0]          hwdata,
  input  wire                 hready,
  output wire                 hreadyout,
  output wire                 hresp,
  output reg  [31:0]          hrdata,
  input  wire                 nmiPin,
  input  wire [EXT_COUNT-1:0] extIrqPinN,
  input  wire [INT_COUNT-1:0] intReq,
  input  wire                 instrDone,
  input  wire [15:0]          instrCode,
  input  wire                 condRegInstr,
  input  wire                 blockMoveByteCount,
  input  wire                 blockMoveWordCount,
  input  wire                 transferBoundary,
  input  wire [23:0]          resumeAddr,
  input  wire [23:0]          blockMoveNextAddr,
  output reg  [3:0]           seqState,
  output reg  [3:0]           acceptedSource,
  output reg  [23:0]          stackedPc,
  output reg                  acceptPulse,
  output reg                  serviceStart,
  output reg                  maskBit,
  output reg                  userMaskBit,
  output reg                  breakMode,
  output wire                 watchdogHalt
);

  localparam SRC_COUNT = 1 + EXT_COUNT + INT_COUNT;
  localparam [3:0] SRC_NONE = 4'hf;
  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_PRIO = 4'h1;
  localparam [3:0] S_WAITEND = 4'h2;
  localparam [3:0] S_PREF_A = 4'h3;
  localparam [3:0] S_INT_A = 4'h4;
  localparam [3:0] S_STACK = 4'h5;
  localparam [3:0] S_VECTOR = 4'h6;
  localparam [3:0] S_PREF_B = 4'h7;
  localparam [3:0] S_INT_B = 4'h8;
  localparam [7:0] COND_RESET = `COND_CODE_RESET;

  // Lowest index wins: NMI, then external, then internal
  function [3:0] bestSource;
    input [SRC_COUNT-1:0] pend;
    integer i;
    begin
      bestSource = SRC_NONE;
      for (i = SRC_COUNT - 1; i >= 0; i = i - 1) begin
        if (pend[i]) begin
          bestSource = i[3:0];
        end
      end
    end
  endfunction

  // Length of one access step minus one, wait states added
  function [4:0] stepLoad;
    input [2:0] memType;
    input [1:0] waits;
    input       half;
    reg   [4:0] base;
    begin
      case (memType)
        `MEM_ONCHIP:       base = `COST_ONCHIP;
        `MEM_8BIT_2STATE:  base = `COST_8BIT_2STATE;
        `MEM_8BIT_3STATE:  base = `COST_8BIT_3STATE;
        `MEM_16BIT_2STATE: base = `COST_16BIT_2STATE;
        `MEM_16BIT_3STATE: base = `COST_16BIT_3STATE;
        default:           base = `COST_ONCHIP;
      endcase
      if (half) begin
        base = base >> 1;
      end
      stepLoad = base + {3'h0, waits} - 5'h01;
    end
  endfunction

  reg  [7:0]           sysCtrl_q;
  reg  [EXT_COUNT-1:0] extEnable_q;
  reg  [EXT_COUNT-1:0] extFlag_q;
  reg  [EXT_COUNT-1:0] extFlag_d;
  reg                  nmiPend_q;
  reg                  nmiPend_d;
  reg  [EXT_COUNT-1:0] extMeta_q;
  reg  [EXT_COUNT-1:0] extSync_q;
  reg  [EXT_COUNT-1:0] extLast_q;
  reg                  nmiMeta_q;
  reg                  nmiSync_q;
  reg                  nmiLast_q;
  reg                  dataWrite_q;
  reg  [7:0]           addr_q;
  reg  [4:0]           cnt_q;
  reg  [3:0]           src_q;
  reg  [31:0]          readData;

  wire                 addrPhase = hsel && htrans[1] && hready;
  wire [EXT_COUNT-1:0] extFall = extLast_q & ~extSync_q;
  wire                 nmiRise = ~nmiLast_q & nmiSync_q;
  wire                 nmiFall = nmiLast_q & ~nmiSync_q;
  wire                 nmiEdge = sysCtrl_q[`NMI_EDGE_BIT] ? nmiRise : nmiFall;
  wire                 wrSys = dataWrite_q && (addr_q == `SYS_CTRL_OFFSET);
  wire                 wrEnable = dataWrite_q && (addr_q == `EXT_ENABLE_OFFSET);
  wire                 wrStatus = dataWrite_q && (addr_q == `EXT_STATUS_OFFSET);
  wire                 wrCond = dataWrite_q && (addr_q == `COND_CODE_OFFSET);
  wire [2:0]           memType = sysCtrl_q[`MEM_TYPE_MSB:`MEM_TYPE_LSB];
  wire [1:0]           waits = sysCtrl_q[`WAIT_MSB:`WAIT_LSB];
  wire                 userMaskMode = ~sysCtrl_q[`USER_MASK_MODE_BIT];
  wire [SRC_COUNT-1:0] pending = {intReq & {INT_COUNT{~maskBit}},
                                  extFlag_q & extEnable_q & {EXT_COUNT{~maskBit}},
                                  nmiPend_q};
  wire [3:0]           curBest = bestSource(pending);
  wire [3:0]           finalSrc = (curBest < src_q) ? curBest : src_q;
  wire                 isBreakEnter = instrDone && (instrCode == `BREAK_ENTER_CODE);
  wire                 isBreakReturn = instrDone && (instrCode == `BREAK_RETURN_CODE);
  wire                 instrAccept = instrDone && !condRegInstr && !isBreakEnter
                                     && !blockMoveByteCount && !blockMoveWordCount;
  wire                 wordNmiAccept = blockMoveWordCount && transferBoundary && nmiPend_q
                                       && !blockMoveByteCount;
  wire                 acceptNow = !breakMode && (instrAccept || wordNmiAccept);
  wire [3:0]           acceptSrc = wordNmiAccept ? 4'h0 : finalSrc;
  wire                 acceptOk = (acceptSrc == 4'h0) || ((acceptSrc != SRC_NONE) && !maskBit);
  wire                 takeNow = (seqState == S_WAITEND) && acceptNow && acceptOk;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign watchdogHalt = breakMode;

  always @* begin
    case (haddr[7:0])
      `SYS_CTRL_OFFSET:   readData = {24'h00_0000, sysCtrl_q};
      `EXT_ENABLE_OFFSET: readData = {{(32-EXT_COUNT){1'b0}}, extEnable_q};
      `EXT_STATUS_OFFSET: readData = {{(32-EXT_COUNT){1'b0}}, extFlag_q};
      `COND_CODE_OFFSET:  readData = {24'h00_0000, maskBit, userMaskBit, 6'h00};
      `SEQ_STATUS_OFFSET: readData = {22'h00_0000, nmiPend_q, breakMode, acceptedSource, seqState};
      `STACKED_PC_OFFSET: readData = {8'h00, stackedPc};
      default:            readData = 32'h0000_0000;
    endcase
  end

  always @* begin
    extFlag_d = extFlag_q;
    if (wrStatus) begin
      extFlag_d = extFlag_q & hwdata[EXT_COUNT-1:0];
    end
    extFlag_d = extFlag_d | extFall;
    nmiPend_d = nmiPend_q;
    if (takeNow && (acceptSrc == 4'h0)) begin
      nmiPend_d = 1'b0;
    end
    nmiPend_d = nmiPend_d | nmiEdge;
  end

  // Pin synchronisers and edge history
  always @(posedge clock) begin
    if (reset) begin
      extMeta_q <= {EXT_COUNT{1'b1}};
      extSync_q <= {EXT_COUNT{1'b1}};
      extLast_q <= {EXT_COUNT{1'b1}};
      nmiMeta_q <= 1'b0;
      nmiSync_q <= 1'b0;
      nmiLast_q <= 1'b0;
    end else begin
      extMeta_q <= extIrqPinN;
      extSync_q <= extMeta_q;
      extLast_q <= extSync_q;
      nmiMeta_q <= nmiPin;
      nmiSync_q <= nmiMeta_q;
      nmiLast_q <= nmiSync_q;
    end
  end

  // Bus slave and software registers
  always @(posedge clock) begin
    if (reset) begin
      dataWrite_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      sysCtrl_q <= `SYS_CTRL_RESET;
      extEnable_q <= {EXT_COUNT{1'b0}};
      extFlag_q <= {EXT_COUNT{1'b0}};
      nmiPend_q <= 1'b0;
    end else begin
      dataWrite_q <= addrPhase && hwrite;
      if (addrPhase) begin
        addr_q <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        hrdata <= readData;
      end
      if (wrSys) begin
        sysCtrl_q <= hwdata[7:0];
      end
      if (wrEnable) begin
        extEnable_q <= hwdata[EXT_COUNT-1:0];
      end
      extFlag_q <= extFlag_d;
      nmiPend_q <= nmiPend_d;
    end
  end

  // Break mode
  always @(posedge clock) begin
    if (reset) begin
      breakMode <= 1'b0;
    end else if (isBreakEnter) begin
      breakMode <= 1'b1;
    end else if (isBreakReturn) begin
      breakMode <= 1'b0;
    end
  end

  // Interrupt sequence, one state per system clock cycle
  always @(posedge clock) begin
    if (reset) begin
      seqState <= S_IDLE;
      cnt_q <= 5'h00;
      src_q <= SRC_NONE;
      acceptedSource <= SRC_NONE;
      stackedPc <= 24'h00_0000;
      acceptPulse <= 1'b0;
      serviceStart <= 1'b0;
      maskBit <= COND_RESET[`COND_MASK_BIT];
      userMaskBit <= 1'b0;
    end else begin
      acceptPulse <= 1'b0;
      serviceStart <= 1'b0;
      if (wrCond) begin
        maskBit <= hwdata[`COND_MASK_BIT];
        userMaskBit <= hwdata[`COND_USER_MASK_BIT];
      end
      case (seqState)
        S_IDLE: begin
          if (curBest != SRC_NONE) begin
            src_q <= curBest;
            seqState <= S_PRIO;
            if (curBest <= EXT_COUNT) begin
              cnt_q <= `PRIO_EXT_STATES - 5'h01;
            end else begin
              cnt_q <= `PRIO_INT_STATES - 5'h01;
            end
          end
        end
        S_PRIO: begin
          if (cnt_q == 5'h00) begin
            seqState <= S_WAITEND;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        S_WAITEND: begin
          if (acceptNow && !acceptOk) begin
            seqState <= S_IDLE;
          end else if (takeNow) begin
            acceptedSource <= acceptSrc;
            stackedPc <= wordNmiAccept ? blockMoveNextAddr : resumeAddr;
            acceptPulse <= 1'b1;
            cnt_q <= stepLoad(memType, waits, 1'b1);
            seqState <= S_PREF_A;
          end
        end
        S_PREF_A: begin
          if (cnt_q == 5'h00) begin
            cnt_q <= `INT_PROC_HALF_STATES - 5'h01;
            seqState <= S_INT_A;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        S_INT_A: begin
          if (cnt_q == 5'h00) begin
            cnt_q <= stepLoad(memType, waits, 1'b0);
            seqState <= S_STACK;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        S_STACK: begin
          if (cnt_q == 5'h00) begin
            maskBit <= 1'b1;
            userMaskBit <= (wrCond ? hwdata[`COND_USER_MASK_BIT] : userMaskBit) | userMaskMode;
            cnt_q <= stepLoad(memType, waits, 1'b0);
            seqState <= S_VECTOR;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        S_VECTOR: begin
          if (cnt_q == 5'h00) begin
            cnt_q <= stepLoad(memType, waits, 1'b1);
            seqState <= S_PREF_B;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        S_PREF_B: begin
          if (cnt_q == 5'h00) begin
            cnt_q <= `INT_PROC_HALF_STATES - 5'h01;
            seqState <= S_INT_B;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        S_INT_B: begin
          if (cnt_q == 5'h00) begin
            serviceStart <= 1'b1;
            src_q <= SRC_NONE;
            seqState <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        default: begin
          seqState <= S_IDLE;
        end
      endcase
    end
  end

endmodule // interrupt_accept_timing

// *** tb/interrupt_accept_timing_monitor.sv ***
// Port checker for sequence timing, inhibition and break mode
`timescale 1ns/1ps
module interrupt_accept_timing_monitor (
  input wire       clock,
  input wire       reset,
  input wire       instrDone,
  input wire       condRegInstr,
  input wire       blockMoveByteCount,
  input wire       blockMoveWordCount,
  input wire       transferBoundary,
  input wire [3:0] seqState,
  input wire       acceptPulse,
  input wire       serviceStart,
  input wire       maskBit,
  input wire       breakMode,
  input wire       watchdogHalt
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  halt_mirror_a: assert property (watchdogHalt == breakMode) else $error("halt differs from break");
  prio_bound_a: assert property (seqState == 4'h1 |-> ##[1:2] seqState != 4'h1)
    else $error("priority decision too long");
  int_first_a: assert property (seqState == 4'h4 && $past(seqState) == 4'h3 |->
    ##1 seqState == 4'h4 ##1 seqState == 4'h5) else $error("first internal step length");
  int_second_a: assert property (seqState == 4'h8 && $past(seqState) == 4'h7 |->
    ##1 seqState == 4'h8 ##1 (seqState == 4'h0 && serviceStart)) else $error("second internal step length");
  break_hold_a: assert property (breakMode && seqState == 4'h2 |=> seqState != 4'h3)
    else $error("accepted in break");
  byte_move_a: assert property (blockMoveByteCount && seqState == 4'h2 |=> seqState != 4'h3)
    else $error("accepted in byte move");
  word_move_a: assert property (blockMoveWordCount && !transferBoundary && seqState == 4'h2 |=>
    seqState != 4'h3) else $error("word move accepted off boundary");
  cond_defer_a: assert property (seqState == 4'h2 && instrDone && condRegInstr |=> seqState != 4'h3)
    else $error("accepted after condition instruction");
  accept_mark_a: assert property (acceptPulse |-> seqState == 4'h3 && $past(seqState) == 4'h2)
    else $error("accept pulse out of place");
  service_mask_a: assert property (serviceStart |-> maskBit && $past(seqState) == 4'h8)
    else $error("service start without mask");
  cover property (acceptPulse);
  cover property (serviceStart);
  cover property ($rose(breakMode));
endmodule // interrupt_accept_timing_monitor
bind interrupt_accept_timing interrupt_accept_timing_monitor mon (
  .clock(clock), .reset(reset), .instrDone(instrDone), .condRegInstr(condRegInstr),
  .blockMoveByteCount(blockMoveByteCount), .blockMoveWordCount(blockMoveWordCount),
  .transferBoundary(transferBoundary), .seqState(seqState), .acceptPulse(acceptPulse), .serviceStart(serviceStart),
  .maskBit(maskBit), .breakMode(breakMode), .watchdogHalt(watchdogHalt));

// *** tb/core_model.sv ***
// Behavioural core: instruction ends, codes and block move activity
`timescale 1ns/1ps
module core_model (
  input  wire        clock,
  input  wire        reset,
  input  wire [15:0] codeReq,
  input  wire        byteMove,
  input  wire        wordMove,
  output reg         instrDone,
  output wire [15:0] instrCode,
  output wire        condRegInstr,
  output wire        blockMoveByteCount,
  output wire        blockMoveWordCount,
  output reg         transferBoundary,
  output wire [23:0] resumeAddr,
  output wire [23:0] blockMoveNextAddr
);
  reg [2:0]  phase_q;
  reg [23:0] pc_q;
  reg        cond_q;
  always @(posedge clock) begin
    if (reset) begin
      phase_q <= 3'h0;
      pc_q <= 24'h00_1000;
      cond_q <= 1'b0;
      instrDone <= 1'b0;
      transferBoundary <= 1'b0;
    end else begin
      phase_q <= phase_q + 3'h1;
      instrDone <= phase_q == 3'h4 && !byteMove && !wordMove; // Move is one long instruction
      transferBoundary <= (byteMove || wordMove) && phase_q[0];
      if (instrDone) begin
        pc_q <= pc_q + 24'h00_0002;
        cond_q <= ~cond_q; // Every other instruction writes the condition register
      end
    end
  end
  assign instrCode = instrDone ? codeReq : ~codeReq; // Code invalid outside the done pulse
  assign condRegInstr = cond_q;
  assign blockMoveByteCount = byteMove;
  assign blockMoveWordCount = wordMove;
  assign resumeAddr = pc_q;
  assign blockMoveNextAddr = pc_q + 24'h00_0004; // Count test and branch follow the move
endmodule // core_model

// *** tb/interrupt_accept_timing_bench.sv ***
// Self-checking bench of interrupt acceptance timing
`timescale 1ns/1ps
`include "interrupt_accept_timing_defs.vh"
`define CHECK(what, expv, gotv) begin samplesChecked++; if ((gotv) !== (expv)) begin \
  $display("wrong value %s expected %0h seen %0h", what, expv, gotv); errTotal++; end end
module interrupt_accept_timing_bench;
  reg         clock;
  reg         reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, nmiPin = 1'b0, byteMove = 1'b0, wordMove = 1'b0;
  reg  [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, seed = 32'h0000_005c;
  reg  [1:0]  htrans = 2'h0;
  reg  [5:0]  extN = 6'h3f;
  reg  [7:0]  intReq = 8'h00;
  reg  [15:0] codeReq = 16'h0000;
  wire        hreadyout, instrDone, condRegInstr, bmb, bmw, tb, serviceStart, userMaskBit, breakMode, watchdogHalt;
  wire [31:0] hrdata;
  wire [23:0] resumeAddr, nextAddr, stackedPc;
  wire [3:0]  seqState, acceptedSource;
  wire [15:0] instrCode;
  integer     errTotal = 0, samplesChecked = 0, n, t, s, k, mt, w, ue;
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  interrupt_accept_timing DUT (
    .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata), .nmiPin(nmiPin),
    .extIrqPinN(extN), .intReq(intReq), .instrDone(instrDone), .instrCode(instrCode), .condRegInstr(condRegInstr),
    .blockMoveByteCount(bmb), .blockMoveWordCount(bmw), .transferBoundary(tb), .resumeAddr(resumeAddr),
    .blockMoveNextAddr(nextAddr), .seqState(seqState), .acceptedSource(acceptedSource), .stackedPc(stackedPc),
    .acceptPulse(), .serviceStart(serviceStart), .maskBit(), .userMaskBit(userMaskBit), .breakMode(breakMode),
    .watchdogHalt(watchdogHalt));
  core_model core (
    .clock(clock), .reset(reset), .codeReq(codeReq), .byteMove(byteMove), .wordMove(wordMove),
    .instrDone(instrDone), .instrCode(instrCode), .condRegInstr(condRegInstr), .blockMoveByteCount(bmb),
    .blockMoveWordCount(bmw), .transferBoundary(tb), .resumeAddr(resumeAddr), .blockMoveNextAddr(nextAddr));
  function automatic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function automatic integer expLen(input integer st, input integer m, input integer wt);
    integer c;
    c = (m == 1) ? 8 : (m == 2) ? 12 : (m == 4) ? 6 : 4;
    expLen = (st == 3 || st == 7) ? c / 2 + wt : (st == 5 || st == 6) ? c + wt : 2;
  endfunction
  task finishTest;
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task stop;
    errTotal++;
    finishTest;
  endtask
  task readyEdge;
    @(posedge clock);
    for (t = 0; t < 3000 && hreadyout !== 1'b1; t++)
      @(posedge clock);
    if (t == 3000)
      stop;
  endtask
  task bus(input wr, input [7:0] a, input [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    readyEdge;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    readyEdge;
    rd = hrdata;
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    `CHECK("register", e, rd)
  endtask
  task waitState(input [3:0] st);
    @(negedge clock);
    for (t = 0; t < 3000 && seqState !== st; t++)
      @(negedge clock);
    if (t == 3000)
      stop;
  endtask
  task lenOf(input [3:0] st);
    for (n = 0; n < 100 && seqState === st; n++)
      @(negedge clock);
    if (n == 100)
      stop;
  endtask
  task sendCode(input [15:0] c);
    @(posedge clock);
    codeReq <= c;
    @(negedge clock);
    for (t = 0; t < 3000 && instrDone !== 1'b1; t++)
      @(negedge clock);
    if (t == 3000)
      stop;
    @(posedge clock);
    codeReq <= 16'h0000;
    @(negedge clock);
  endtask
  task nmiMove(input b, input wd);
    @(posedge clock);
    nmiPin <= 1'b1;
    byteMove <= b;
    wordMove <= wd;
    repeat (5) @(posedge clock);
    nmiPin <= 1'b0;
    repeat (12) @(negedge clock);
    `CHECK("accept in move", wd, seqState > 4'h2)
  endtask
  task resetRegs;
    rdc(`SYS_CTRL_OFFSET, 32'h0000_0002);
    rdc(`COND_CODE_OFFSET, 32'h0000_0080);
    rdc(`SEQ_STATUS_OFFSET, 32'h0000_00f0);
    rdc(8'h20, 32'h0000_0000);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    resetRegs;
    bus(1'b1, `EXT_ENABLE_OFFSET, 32'h0000_0001);
    for (mt = 0; mt < 5; mt++) begin
      w = rnd() % 4;
      ue = rnd() % 2;
      bus(1'b1, `SYS_CTRL_OFFSET, (w << 5) | (mt << 2) | (ue << 1));
      bus(1'b1, `COND_CODE_OFFSET, 32'h0000_0000);
      extN[0] <= 1'b0;
      waitState(4'h1);
      lenOf(4'h1);
      `CHECK("ext decision", 2, n)
      waitState(4'h3);
      `CHECK("ext source", 4'h1, acceptedSource)
      for (s = 3; s < 9; s++) begin
        lenOf(s);
        `CHECK("step length", expLen(s, mt, w), n)
      end
      `CHECK("service start", 1'b1, serviceStart)
      `CHECK("user mask", ~ue[0], userMaskBit)
      bus(1'b1, `EXT_STATUS_OFFSET, 32'h0000_003f);
      extN[0] <= 1'b1;
      rdc(`EXT_STATUS_OFFSET, 32'h0000_0001);
      bus(1'b1, `EXT_STATUS_OFFSET, 32'h0000_003e);
      rdc(`EXT_STATUS_OFFSET, 32'h0000_0000);
      $display("ext sequence on memory type %0d done", mt);
    end
    extN[1] <= 1'b0;
    repeat (6) @(posedge clock);
    rdc(`EXT_STATUS_OFFSET, 32'h0000_0002);
    extN[2] <= 1'b0;
    repeat (6) @(posedge clock);
    bus(1'b1, `EXT_STATUS_OFFSET, 32'h0000_0000);
    rdc(`EXT_STATUS_OFFSET, 32'h0000_0000);
    bus(1'b1, `COND_CODE_OFFSET, 32'h0000_0000);
    k = rnd() % 8;
    intReq[k] <= 1'b1;
    waitState(4'h1);
    lenOf(4'h1);
    `CHECK("int decision", 1, n)
    waitState(4'h3);
    `CHECK("int source", 7 + k, acceptedSource)
    @(posedge clock);
    intReq <= 8'h00;
    waitState(4'h0);
    $display("flag and internal tests done");
    bus(1'b1, `SYS_CTRL_OFFSET, 32'h0000_0003);
    sendCode(`BREAK_ENTER_CODE);
    `CHECK("break mode", 1'b1, breakMode)
    `CHECK("watchdog halt", 1'b1, watchdogHalt)
    @(posedge clock);
    nmiPin <= 1'b1;
    repeat (40) @(negedge clock);
    `CHECK("held in break", 1'b0, seqState > 4'h2)
    sendCode(`BREAK_RETURN_CODE);
    `CHECK("break left", 1'b0, breakMode)
    waitState(4'h3);
    `CHECK("nmi rising", 4'h0, acceptedSource)
    waitState(4'h0);
    bus(1'b1, `SYS_CTRL_OFFSET, 32'h0000_0002);
    nmiPin <= 1'b0;
    waitState(4'h3);
    `CHECK("nmi falling", 4'h0, acceptedSource)
    waitState(4'h0);
    sendCode(`BREAK_ENTER_CODE);
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    `CHECK("break after reset", 1'b0, breakMode)
    resetRegs;
    $display("nmi and break tests done");
    nmiMove(1'b1, 1'b0);
    @(posedge clock);
    byteMove <= 1'b0;
    waitState(4'h3);
    `CHECK("nmi after byte move", 4'h0, acceptedSource)
    waitState(4'h0);
    nmiMove(1'b0, 1'b1);
    `CHECK("stacked address", nextAddr, stackedPc)
    @(posedge clock);
    wordMove <= 1'b0;
    waitState(4'h0);
    $display("block move tests done");
    finishTest;
  end
endmodule // interrupt_accept_timing_bench
